/* src/dlc_pkg.sv */
// Shared constants, enumerations and carriers for the level-one data cache block.
// Assumes a single core clock domain and a synchronous active-low reset.
package dlc_pkg;
  localparam int ADDR_W = 32;
  localparam int LINE_W = 26;
  localparam int LINE_LSB = 6;
  localparam int SET_W = 6;
  localparam int SETS = 64;
  localparam int WAYS = 3;
  localparam int TAG_W = 20;
  localparam int LINE_BITS = 512;
  localparam int WSEL_W = 4;
  localparam int IDX_W = 8;
  localparam int SPAN_W = 12;
  localparam int OP_COUNT = 7;
  localparam logic [1:0] OLDEST_AGE = 2'h2;
  localparam logic [15:0] WORD_LIMIT = 16'hff80;
  localparam logic [SPAN_W-1:0] SPAN_LAST = 12'h001;

  typedef enum logic [2:0] {
    OP_L2_WB = 3'h0,
    OP_L2_WBI = 3'h1,
    OP_L2_INV = 3'h2,
    OP_L1P_INV = 3'h3,
    OP_L1D_WBI = 3'h4,
    OP_L1D_WB = 3'h5,
    OP_L1D_INV = 3'h6
  } dlc_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_FILL = 2'b11,
    ST_MAINT = 2'b10
  } dlc_state_type;

  typedef struct packed {
    logic valid;
    logic pred_true;
    logic store;
    logic cacheable;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } dlc_req_type;

  typedef struct packed {
    logic valid;
    logic [LINE_W-1:0] line;
    logic [LINE_BITS-1:0] data;
  } dlc_line_type;

  typedef struct packed {
    logic valid;
    dlc_op_type op;
    logic [LINE_W-1:0] line;
  } dlc_step_type;

  localparam dlc_req_type REQ_RESET = '0;
  localparam dlc_line_type LINE_RESET = '0;
  localparam dlc_step_type STEP_RESET = '0;
endpackage

/* src/dlc_block_walker.sv */
// Block maintenance walker: turns a word-count write into one step per cache line.
// Assumes the cache consumes a step in the cycle it raises step_ready.
`timescale 1ns/10ps
module dlc_block_walker (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [dlc_pkg::OP_COUNT-1:0] wc_write, // One-hot write to a word-count register
  input wire logic [15:0] block_word_count, // Word count being written
  input wire logic [dlc_pkg::ADDR_W-1:0] block_base, // Base address of the range
  input wire logic step_ready, // Cache takes the current step
  output dlc_pkg::dlc_step_type step, // Current line step
  output logic busy, // Walk in progress
  output logic reject // Write refused, one-cycle pulse
);
  dlc_pkg::dlc_step_type next_step;
  logic next_busy;
  logic next_reject;
  logic [dlc_pkg::SPAN_W-1:0] remain;
  logic [dlc_pkg::SPAN_W-1:0] next_remain;
  logic [dlc_pkg::ADDR_W-1:0] last_addr;
  logic [dlc_pkg::LINE_W-1:0] line_diff;
  dlc_pkg::dlc_op_type sel_op;
  logic start;

  always_comb begin
    last_addr = block_base + {14'h0, block_word_count, 2'h0} - 32'h1;
    line_diff = last_addr[31:dlc_pkg::LINE_LSB] - block_base[31:dlc_pkg::LINE_LSB];
    sel_op = dlc_pkg::OP_L2_WB;
    for (int i = dlc_pkg::OP_COUNT - 1; i >= 0; i--) begin
      if (wc_write[i]) begin
        sel_op = dlc_pkg::dlc_op_type'(3'(i));
      end
    end
    start = 1'b0;
    next_step = step;
    next_busy = busy;
    next_remain = remain;
    next_reject = 1'b0;
    if (|wc_write) begin
      // A second write during a walk would corrupt the range, so it is refused
      if (busy || block_word_count > dlc_pkg::WORD_LIMIT) begin
        next_reject = 1'b1;
      end else if (block_word_count != 16'h0) begin
        start = 1'b1;
      end
    end
    if (start) begin
      next_busy = 1'b1;
      next_step.valid = 1'b1;
      next_step.op = sel_op;
      next_step.line = block_base[31:dlc_pkg::LINE_LSB];
      next_remain = line_diff[dlc_pkg::SPAN_W-1:0] + dlc_pkg::SPAN_LAST;
    end else if (busy && step_ready) begin
      next_step.line = step.line + 26'h1;
      next_remain = remain - dlc_pkg::SPAN_LAST;
      if (remain == dlc_pkg::SPAN_LAST) begin
        next_busy = 1'b0;
        next_step.valid = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      step <= dlc_pkg::STEP_RESET;
      busy <= 1'b0;
      reject <= 1'b0;
      remain <= '0;
    end else begin
      step <= next_step;
      busy <= next_busy;
      reject <= next_reject;
      remain <= next_remain;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  word_limit_a: assert property ((|wc_write) && block_word_count > dlc_pkg::WORD_LIMIT |=> reject && !$rose(busy))
    else $error("over-limit word count was not refused");
  walk_start_a: assert property (start |=> busy && step.line == $past(block_base[31:6]))
    else $error("walk did not start at the base line");
  walk_end_a: assert property (busy && step_ready && remain == 12'h1 |=> !busy && !step.valid)
    else $error("walk did not stop after its last line");
endmodule

/* src/dlc_data_cache.sv */
// Three-way level-one data cache with victim announcement and block maintenance.
// Assumes the second-level side answers each fill_req with one fill_valid beat and
// accepts a victim beat whenever victim.valid is high.
`timescale 1ns/10ps
module dlc_data_cache (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire dlc_pkg::dlc_req_type first_datapath_side, // Access from first side
  input wire dlc_pkg::dlc_req_type second_datapath_side, // Access from second side
  output logic req_ready, // Cache takes an access pair this cycle
  output logic ld_done, // Load data valid, one-cycle pulse
  output logic [31:0] ld_data, // Load data
  output logic victim_expect, // Victim announced, one-cycle pulse
  output logic [dlc_pkg::SET_W-1:0] victim_set, // Set of the announced victim
  output dlc_pkg::dlc_line_type victim, // Victim writeback beat
  output logic fill_req, // Line fetch request, one-cycle pulse
  output logic [dlc_pkg::LINE_W-1:0] fill_line, // Line being fetched
  input wire logic fill_valid, // Fetched line arrives
  input wire logic [dlc_pkg::LINE_BITS-1:0] fill_data, // Fetched line
  input wire logic [dlc_pkg::OP_COUNT-1:0] wc_write, // One-hot word-count register write
  input wire logic [15:0] block_word_count, // Word count written
  input wire logic [dlc_pkg::ADDR_W-1:0] block_base, // Base address of the block operation
  output logic maint_busy, // Block operation running
  output logic maint_reject, // Word-count write refused, pulse
  output dlc_pkg::dlc_step_type ext_maint // Line step for second level or program cache
);
  localparam int NENT = dlc_pkg::SETS * dlc_pkg::WAYS;

  dlc_pkg::dlc_state_type state, next_state;
  dlc_pkg::dlc_req_type cur, next_cur, pend, next_pend;
  dlc_pkg::dlc_line_type next_victim;
  dlc_pkg::dlc_step_type step, next_ext;
  logic hz, next_hz;
  logic [1:0] way_sel, next_way;
  logic next_ready, next_ld_done, next_vexp, next_fill_req;
  logic [31:0] next_ld_data;
  logic [dlc_pkg::SET_W-1:0] next_vset;
  logic [dlc_pkg::LINE_W-1:0] next_fill_line;

  logic [dlc_pkg::TAG_W-1:0] tag_mem [NENT];
  logic [dlc_pkg::LINE_BITS-1:0] data_mem [NENT];
  logic [1:0] age_mem [NENT];
  logic [NENT-1:0] valid_bits, dirty_bits;

  logic [dlc_pkg::LINE_W-1:0] lk_line;
  logic [dlc_pkg::SET_W-1:0] lk_set;
  logic [dlc_pkg::TAG_W-1:0] lk_tag;
  logic [dlc_pkg::IDX_W-1:0] way_idx [dlc_pkg::WAYS];
  logic [dlc_pkg::WAYS-1:0] hit_vec, way_valid, way_old;
  logic [1:0] hit_way, repl_way;
  logic all_valid, lru_dirty, step_ready, eff_cache;
  logic [31:0] fill_word;

  logic wr_en, wr_dirty, install_en, touch_en, clr_valid, clr_dirty, hz_fire;
  logic [1:0] touch_way;
  logic [dlc_pkg::IDX_W-1:0] wr_idx;
  logic [dlc_pkg::LINE_BITS-1:0] wr_data;

  function automatic logic [dlc_pkg::IDX_W-1:0] ent(input logic [dlc_pkg::SET_W-1:0] s, input logic [1:0] w);
    ent = {2'h0, s} * 8'h03 + {6'h0, w};
  endfunction

  function automatic logic [dlc_pkg::LINE_BITS-1:0] merge(input logic [dlc_pkg::LINE_BITS-1:0] l,
      input logic [dlc_pkg::WSEL_W-1:0] sel, input logic [31:0] d);
    logic [dlc_pkg::LINE_BITS-1:0] r;
    r = l;
    r[sel*32 +: 32] = d;
    merge = r;
  endfunction

  dlc_block_walker u_walker (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wc_write(wc_write),
    .block_word_count(block_word_count),
    .block_base(block_base),
    .step_ready(step_ready),
    .step(step),
    .busy(maint_busy),
    .reject(maint_reject)
  );

  // Line address is the upper 26 bits of the byte address
  assign lk_line = (state == dlc_pkg::ST_MAINT) ? step.line : cur.addr[31:dlc_pkg::LINE_LSB];
  assign lk_set = lk_line[dlc_pkg::SET_W-1:0];
  assign lk_tag = lk_line[dlc_pkg::LINE_W-1:dlc_pkg::SET_W];
  assign step_ready = (state == dlc_pkg::ST_MAINT);
  assign eff_cache = cur.cacheable | cur.store;
  assign fill_word = fill_data[cur.addr[5:2]*32 +: 32];

  for (genvar w = 0; w < dlc_pkg::WAYS; w++) begin : g_way
    assign way_idx[w] = ent(lk_set, 2'(w));
    assign hit_vec[w] = valid_bits[way_idx[w]] && tag_mem[way_idx[w]] == lk_tag;
    assign way_valid[w] = valid_bits[way_idx[w]];
    assign way_old[w] = age_mem[way_idx[w]] == dlc_pkg::OLDEST_AGE;
  end

  always_comb begin
    hit_way = 2'h0;
    repl_way = 2'h0;
    for (int w = dlc_pkg::WAYS - 1; w >= 0; w--) begin
      if (hit_vec[w]) begin
        hit_way = 2'(w);
      end
      if (way_old[w]) begin
        repl_way = 2'(w);
      end
    end
    all_valid = &way_valid;
    if (!all_valid) begin
      for (int w = dlc_pkg::WAYS - 1; w >= 0; w--) begin
        if (!way_valid[w]) begin
          repl_way = 2'(w);
        end
      end
    end
    lru_dirty = all_valid && dirty_bits[ent(lk_set, repl_way)];
  end

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_pend = pend;
    next_hz = hz;
    next_way = way_sel;
    next_ld_done = 1'b0;
    next_ld_data = ld_data;
    next_vexp = 1'b0;
    next_vset = victim_set;
    next_victim = victim;
    next_victim.valid = 1'b0;
    next_fill_req = 1'b0;
    next_fill_line = fill_line;
    next_ext = ext_maint;
    next_ext.valid = 1'b0;
    wr_en = 1'b0;
    wr_dirty = 1'b0;
    wr_idx = ent(lk_set, hit_way);
    wr_data = data_mem[ent(lk_set, hit_way)];
    install_en = 1'b0;
    touch_en = 1'b0;
    touch_way = hit_way;
    clr_valid = 1'b0;
    clr_dirty = 1'b0;
    hz_fire = 1'b0;
    case (state)
      dlc_pkg::ST_IDLE: begin
        if (first_datapath_side.valid || second_datapath_side.valid) begin
          next_hz = first_datapath_side.valid && second_datapath_side.valid
            && !first_datapath_side.pred_true && second_datapath_side.pred_true
            && !first_datapath_side.store && !second_datapath_side.store
            && first_datapath_side.addr[31:6] == second_datapath_side.addr[31:6];
          // False-predicated accesses are discarded; a true pair is served first side first
          if (first_datapath_side.valid && first_datapath_side.pred_true) begin
            next_cur = first_datapath_side;
            next_pend = second_datapath_side;
            next_pend.valid = second_datapath_side.valid && second_datapath_side.pred_true;
            next_state = dlc_pkg::ST_LOOK;
          end else if (second_datapath_side.valid && second_datapath_side.pred_true) begin
            next_cur = second_datapath_side;
            next_pend.valid = 1'b0;
            next_state = dlc_pkg::ST_LOOK;
          end
        end else if (step.valid) begin
          next_state = dlc_pkg::ST_MAINT;
        end
      end
      dlc_pkg::ST_LOOK: begin
        if (|hit_vec) begin
          touch_en = 1'b1;
          if (cur.store) begin
            wr_en = 1'b1;
            wr_dirty = 1'b1;
            wr_data = merge(data_mem[ent(lk_set, hit_way)], cur.addr[5:2], cur.wdata);
          end else begin
            next_ld_done = 1'b1;
            next_ld_data = data_mem[ent(lk_set, hit_way)][cur.addr[5:2]*32 +: 32];
          end
          next_state = dlc_pkg::ST_IDLE;
        end else begin
          next_way = repl_way;
          if (lru_dirty && (eff_cache || hz)) begin
            next_vexp = 1'b1;
            next_vset = lk_set;
            if (hz) begin
              hz_fire = 1'b1;
            end else begin
              next_victim.valid = 1'b1;
              next_victim.line = {tag_mem[ent(lk_set, repl_way)], lk_set};
              next_victim.data = data_mem[ent(lk_set, repl_way)];
            end
          end
          next_fill_req = 1'b1;
          next_fill_line = lk_line;
          next_state = dlc_pkg::ST_FILL;
        end
      end
      dlc_pkg::ST_FILL: begin
        if (fill_valid) begin
          // A cacheable hazard install overwrites the dirty way with no writeback, so its data is gone
          if (eff_cache) begin
            install_en = 1'b1;
            wr_en = 1'b1;
            wr_idx = ent(lk_set, way_sel);
            wr_dirty = cur.store;
            wr_data = cur.store ? merge(fill_data, cur.addr[5:2], cur.wdata) : fill_data;
            touch_en = 1'b1;
            touch_way = way_sel;
          end
          if (!cur.store) begin
            next_ld_done = 1'b1;
            next_ld_data = fill_word;
          end
          next_state = dlc_pkg::ST_IDLE;
        end
      end
      dlc_pkg::ST_MAINT: begin
        if (step.op == dlc_pkg::OP_L1D_WBI || step.op == dlc_pkg::OP_L1D_WB || step.op == dlc_pkg::OP_L1D_INV) begin
          if (|hit_vec) begin
            if (step.op != dlc_pkg::OP_L1D_INV && dirty_bits[ent(lk_set, hit_way)]) begin
              next_victim.valid = 1'b1;
              next_victim.line = lk_line;
              next_victim.data = data_mem[ent(lk_set, hit_way)];
            end
            clr_dirty = 1'b1;
            clr_valid = step.op != dlc_pkg::OP_L1D_WB;
          end
        end else begin
          next_ext = step;
        end
        next_state = dlc_pkg::ST_IDLE;
      end
      default: next_state = dlc_pkg::ST_IDLE;
    endcase
    if (next_state == dlc_pkg::ST_IDLE && state != dlc_pkg::ST_IDLE) begin
      next_hz = 1'b0;
      if (pend.valid) begin
        next_cur = pend;
        next_pend.valid = 1'b0;
        next_state = dlc_pkg::ST_LOOK;
      end
    end
    next_ready = (next_state == dlc_pkg::ST_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= dlc_pkg::ST_IDLE;
      cur <= dlc_pkg::REQ_RESET;
      pend <= dlc_pkg::REQ_RESET;
      hz <= 1'b0;
      way_sel <= 2'h0;
      req_ready <= 1'b0;
      ld_done <= 1'b0;
      ld_data <= 32'h0;
      victim_expect <= 1'b0;
      victim_set <= 6'h00;
      victim <= dlc_pkg::LINE_RESET;
      fill_req <= 1'b0;
      fill_line <= 26'h0;
      ext_maint <= dlc_pkg::STEP_RESET;
    end else begin
      state <= next_state;
      cur <= next_cur;
      pend <= next_pend;
      hz <= next_hz;
      way_sel <= next_way;
      req_ready <= next_ready;
      ld_done <= next_ld_done;
      ld_data <= next_ld_data;
      victim_expect <= next_vexp;
      victim_set <= next_vset;
      victim <= next_victim;
      fill_req <= next_fill_req;
      fill_line <= next_fill_line;
      ext_maint <= next_ext;
    end
  end

  // Line storage has no reset; valid and dirty bits are cleared and each age is loaded with its way number
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      data_mem[wr_idx] <= wr_data;
    end
    if (install_en) begin
      tag_mem[wr_idx] <= lk_tag;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      valid_bits <= '0;
      dirty_bits <= '0;
      for (int i = 0; i < NENT; i++) begin
        age_mem[i] <= 2'(i % dlc_pkg::WAYS);
      end
    end else begin
      if (install_en) begin
        valid_bits[wr_idx] <= 1'b1;
      end
      if (wr_en) begin
        dirty_bits[wr_idx] <= wr_dirty;
      end
      if (clr_dirty) begin
        dirty_bits[wr_idx] <= 1'b0;
      end
      if (clr_valid) begin
        valid_bits[wr_idx] <= 1'b0;
      end
      if (touch_en) begin
        for (int w = 0; w < dlc_pkg::WAYS; w++) begin
          if (2'(w) == touch_way) begin
            age_mem[way_idx[w]] <= 2'h0;
          end else if (age_mem[way_idx[w]] < age_mem[ent(lk_set, touch_way)]) begin
            age_mem[way_idx[w]] <= age_mem[way_idx[w]] + 2'h1;
          end
        end
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence hz_miss_s;
    state == dlc_pkg::ST_LOOK && hz && hit_vec == 3'h0 && all_valid && lru_dirty;
  endsequence
  sequence fill_load_s;
    state == dlc_pkg::ST_FILL && fill_valid && !cur.store;
  endsequence

  line_match_a: assert property (state == dlc_pkg::ST_IDLE && first_datapath_side.valid && second_datapath_side.valid
      && first_datapath_side.addr[31:6] != second_datapath_side.addr[31:6] |=> !hz)
    else $error("hazard latched for loads to different lines");
  hazard_cause_a: assert property (hz_fire |-> all_valid && lru_dirty && hit_vec == 3'h0 && cur.pred_true
      && $past(first_datapath_side.valid) && !$past(first_datapath_side.pred_true))
    else $error("hazard fired without its conditions");
  victim_announce_a: assert property (hz_miss_s |=> victim_expect && victim_set == $past(lk_set))
    else $error("hazard victim not announced for its set");
  no_victim_a: assert property (hz_fire |=> !victim.valid [*3])
    else $error("announced hazard victim was delivered");
  true_load_a: assert property (fill_load_s |=> ld_done && ld_data == $past(fill_word))
    else $error("load did not complete with fetched data");
  miss_fetch_a: assert property (state == dlc_pkg::ST_LOOK && hit_vec == 3'h0 |=> fill_req ##0 state == dlc_pkg::ST_FILL)
    else $error("miss did not request a line");
  dirty_lost_a: assert property (state == dlc_pkg::ST_FILL && fill_valid && hz && cur.cacheable |-> install_en && !wr_dirty)
    else $error("cacheable hazard did not overwrite the dirty line");
  keep_dirty_a: assert property (state == dlc_pkg::ST_FILL && !cur.cacheable && !cur.store |-> !install_en)
    else $error("non-cacheable fill replaced a line");
endmodule

/* sim/dlc_l2_model.sv */
// Second-level memory model: answers line fetches and holds off transfer engines per set.
// Assumes one fetch outstanding and a victim beat taken whenever it is valid.
`timescale 1ns/10ps
module dlc_l2_model (
  input wire logic core_clk, // Core clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic slow, // Answer fetches late
  input wire logic fill_req, // Fetch request
  input wire logic [dlc_pkg::LINE_W-1:0] fill_line, // Line fetched
  output logic fill_valid, // Fetch answer
  output logic [dlc_pkg::LINE_BITS-1:0] fill_data, // Line data
  input wire logic victim_expect, // Victim announced
  input wire logic [dlc_pkg::SET_W-1:0] victim_set, // Announced set
  input wire dlc_pkg::dlc_line_type victim, // Victim beat
  output logic [dlc_pkg::SETS-1:0] hold_off, // Transfer engines held per set
  output int victims_seen, // Victim beats taken
  output dlc_pkg::dlc_line_type last_victim // Last victim beat
);
  logic pend;
  logic [3:0] wait_cnt;
  logic [dlc_pkg::LINE_W-1:0] line_q;

  function automatic logic [31:0] mem_word(input logic [25:0] ln, input int w);
    return {ln[21:0], 6'h2b, w[3:0]};
  endfunction

  always_ff @(posedge core_clk) begin
    fill_valid <= 1'b0;
    // Released bus toggles so stale data never looks valid
    fill_data <= ~fill_data;
    if (!rst_n) begin
      pend <= 1'b0;
      hold_off <= '0;
      victims_seen <= 0;
      fill_data <= '0;
      last_victim <= '0;
    end else begin
      if (fill_req) begin
        pend <= 1'b1;
        line_q <= fill_line;
        wait_cnt <= slow ? 4'hc : 4'h1;
      end else if (pend && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        fill_valid <= 1'b1;
        for (int w = 0; w < 16; w++) begin
          fill_data[w*32 +: 32] <= mem_word(line_q, w);
        end
      end
      if (victim_expect) begin
        hold_off[victim_set] <= 1'b1;
      end
      if (victim.valid) begin
        hold_off[victim.line[5:0]] <= 1'b0;
        victims_seen <= victims_seen + 1;
        last_victim <= victim;
      end
    end
  end
endmodule

/* sim/dlc_data_cache_bench.sv */
// Bench for the level-one data cache: loads, victim hazard and block maintenance.
// Assumes the second-level model faces the cache and answers every fetch.
`timescale 1ns/10ps
module dlc_data_cache_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  dlc_pkg::dlc_req_type a_req = dlc_pkg::REQ_RESET;
  dlc_pkg::dlc_req_type b_req = dlc_pkg::REQ_RESET;
  logic req_ready, ld_done, victim_expect, fill_req, fill_valid, maint_busy, maint_reject;
  logic [31:0] ld_data;
  logic [dlc_pkg::SET_W-1:0] victim_set;
  dlc_pkg::dlc_line_type victim, last_victim;
  dlc_pkg::dlc_step_type ext_maint;
  logic [25:0] fill_line;
  logic [511:0] fill_data;
  logic [6:0] wc_write = '0;
  logic [15:0] wcount = '0;
  logic [31:0] wbase = '0;
  logic [63:0] hold_off;
  int victims_seen, fail_count, samples_checked, cycles;

  always #5 core_clk = ~core_clk;

  dlc_data_cache i_dut (.core_clk(core_clk), .rst_n(rst_n), .first_datapath_side(a_req),
    .second_datapath_side(b_req), .req_ready(req_ready), .ld_done(ld_done), .ld_data(ld_data),
    .victim_expect(victim_expect), .victim_set(victim_set), .victim(victim), .fill_req(fill_req),
    .fill_line(fill_line), .fill_valid(fill_valid), .fill_data(fill_data), .wc_write(wc_write),
    .block_word_count(wcount), .block_base(wbase), .maint_busy(maint_busy),
    .maint_reject(maint_reject), .ext_maint(ext_maint));

  dlc_l2_model i_l2 (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .fill_req(fill_req),
    .fill_line(fill_line), .fill_valid(fill_valid), .fill_data(fill_data),
    .victim_expect(victim_expect), .victim_set(victim_set), .victim(victim),
    .hold_off(hold_off), .victims_seen(victims_seen), .last_victim(last_victim));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] ad(input logic [19:0] tag, input logic [5:0] s, input logic [3:0] w);
    return {tag, s, w, 2'b00};
  endfunction

  function automatic dlc_pkg::dlc_req_type mk(input logic p, st, c, input logic [31:0] a, wd);
    return '{1'b1, p, st, c, a, wd};
  endfunction

  // Request is held until the edge that samples req_ready high
  task automatic issue(input dlc_pkg::dlc_req_type a, input dlc_pkg::dlc_req_type b);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    a_req = a;
    b_req = b;
    @(posedge core_clk);
    #1;
    a_req = dlc_pkg::REQ_RESET;
    b_req = dlc_pkg::REQ_RESET;
  endtask

  task automatic wait_ld(output logic [31:0] d, output int n, output logic f, output logic e);
    f = 1'b0;
    e = 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      f |= fill_req;
      e |= victim_expect & fill_req;
    end while (ld_done !== 1'b1 && n < 60);
    d = ld_data;
  endtask

  task automatic do_wc(input int op, input logic [15:0] cnt, input logic [31:0] base);
    @(posedge core_clk);
    #1;
    wc_write = 7'h1 << op;
    wcount = cnt;
    wbase = base;
    @(posedge core_clk);
    #1;
    wc_write = '0;
  endtask

  // Dirty oldest way, then two clean ways: the set is full
  task automatic setup_set(input logic [5:0] s);
    logic [31:0] d;
    int n;
    logic f, e;
    issue(mk(1, 1, 1, ad(20'h100, s, 0), 32'hc0de0000 | s), '0);
    for (int t = 1; t < 3; t++) begin
      issue(mk(1, 0, 1, ad(20'h100 + t, s, 0), 0), '0);
      wait_ld(d, n, f, e);
    end
  endtask

  task automatic t_evict();
    logic [31:0] d;
    int n, v0;
    logic f, e;
    setup_set(6'h09);
    v0 = victims_seen;
    issue(mk(0, 0, 1, ad(20'h104, 6'h09, 1), 0), mk(1, 0, 1, ad(20'h103, 6'h09, 2), 0));
    wait_ld(d, n, f, e);
    check("victim beats", victims_seen, v0 + 1);
    check("victim line", last_victim.line, {20'h100, 6'h09});
    check("victim word", last_victim.data[31:0], 32'hc0de0009);
    check("load data", d, i_l2.mem_word({20'h103, 6'h09}, 2));
  endtask

  task automatic t_hazard(input logic cch, input logic [5:0] s);
    logic [31:0] d;
    int n, v0;
    logic f, e;
    setup_set(s);
    v0 = victims_seen;
    issue(mk(0, 0, cch, ad(20'h103, s, 4), 0), mk(1, 0, cch, ad(20'h103, s, 9), 0));
    wait_ld(d, n, f, e);
    check("announce with fetch", e, 1);
    check("announced set", victim_set, s);
    check("fetched line", fill_line, {20'h103, s});
    check("true load data", d, i_l2.mem_word({20'h103, s}, 9));
    repeat (30) @(posedge core_clk);
    #1;
    check("victim beats", victims_seen, v0);
    check("transfer hold-off", hold_off[s], 1);
    issue(mk(1, 0, 1, ad(20'h100, s, 0), 0), '0);
    wait_ld(d, n, f, e);
    if (cch) begin
      check("lost line refetched", f, 1);
      check("lost line data", d, i_l2.mem_word({20'h100, s}, 0));
    end else begin
      check("kept line latency", n, 1);
      check("kept line data", d, 32'hc0de0000 | s);
    end
  endtask

  // Range starts one word before a line end, so it spans two lines
  task automatic t_maint_ext();
    int k;
    for (int op = 0; op < 4; op++) begin
      k = 0;
      do_wc(op, 16'h2, ad(20'h200, 6'h05, 4'hf));
      for (int c = 0; c < 40; c++) begin
        @(posedge core_clk);
        #1;
        if (ext_maint.valid === 1'b1) begin
          check("step op", ext_maint.op, op);
          check("step line", ext_maint.line, {20'h200, 6'h05} + k);
          k++;
        end
      end
      check("step count", k, 2);
    end
  endtask

  task automatic t_maint_limit();
    int n;
    do_wc(6, 16'hff81, '0);
    check("over limit refused", maint_reject, 1);
    check("over limit idle", maint_busy, 0);
    do_wc(4, dlc_pkg::WORD_LIMIT, '0);
    check("limit accepted", maint_busy, 1);
    check("limit not refused", maint_reject, 0);
    do_wc(6, 16'h1, '0);
    check("busy write refused", maint_reject, 1);
    n = 0;
    while (maint_busy === 1'b1 && n < 40000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("first piece done", maint_busy, 0);
    do_wc(5, 16'h80, 32'h3fe00);
    check("second piece runs", maint_busy, 1);
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_evict();
    slow = 1'b1;
    t_hazard(1'b1, 6'h11);
    slow = 1'b0;
    t_hazard(1'b0, 6'h22);
    t_maint_ext();
    t_maint_limit();
    tally_and_finish();
  end
endmodule
